// file: hdl/fpp_pkg.sv
// Register map, fixed bit layouts and reset values for the parallel ports
package fpp_pkg;

    // Register offsets on the internal bus
    localparam logic [2:0] OFS_A_DATA = 3'h0;
    localparam logic [2:0] OFS_B_DATA = 3'h1;
    localparam logic [2:0] OFS_C_DATA = 3'h2;
    localparam logic [2:0] OFS_D_DATA = 3'h3;
    localparam logic [2:0] OFS_A_DIR = 3'h4;
    localparam logic [2:0] OFS_B_DIR = 3'h5;
    localparam logic [2:0] OFS_C_DIR = 3'h6;
    localparam logic [2:0] OFS_D_DIR = 3'h7;

    // Implemented bits and constant read values of the narrow ports
    localparam logic [7:0] B_MASK = 8'hE0;
    localparam logic [7:0] B_DATA_FIX = 8'h00;
    localparam logic [7:0] B_DIR_FIX = 8'h1F;
    localparam logic [7:0] D_DATA_MASK = 8'hA0;
    localparam logic [7:0] D_DATA_FIX = 8'h10;
    localparam logic [7:0] D_DIR_MASK = 8'h20;
    localparam logic [7:0] D_DIR_FIX = 8'h00;

    // Field positions inside port B and port D
    localparam int B_SDO_BIT = 5;
    localparam int B_SDI_BIT = 6;
    localparam int B_SCK_BIT = 7;
    localparam int D_IO_BIT = 5;
    localparam int D_CAP_BIT = 7;

    // Reset values
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage

// file: hdl/fpp_ports.sv
// Four parallel I/O ports with direction control and port A interrupts
//
// Function
// - Port A eight bits, data 0, direction 4
// - Port B three bits, data 1, direction 5
// - Port B pins carry serial out, in, clock
// - Port C eight bits, data 2, direction 6
// - Port D bit5 I/O, bit7 capture input
// - Reset clears directions, keeps data latches
// - Direction one means output, zero input
// - Capture pin always readable through port D
// - Write with direction zero only latches
// - Write with direction one latches and drives
// - Read with direction zero returns pin level
// - Read with direction one returns latch
// - Port A pullup and interrupt by build option
// - Port A interrupt only while pin is input
// - Falling edge of combined sources sets latch
`timescale 1ns/1ps

module fpp_ports #(
    parameter logic [7:0] PULLUP_MASK = 8'h00,
    parameter logic [7:0] IRQ_MASK = 8'h00,
    parameter bit LEVEL_SENSE = 1'b0
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SEL,
    input wire logic RW,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic [7:0] FIRST_PORT_PINS_IN,
    output logic [7:0] FIRST_PORT_PINS_OUT,
    output logic [7:0] FIRST_PORT_PINS_OE,
    output logic [7:0] FIRST_PORT_PULLUP,
    input wire logic SERIAL_OUT_SHARED_PIN_IN,
    output logic SERIAL_OUT_SHARED_PIN_OUT,
    output logic SERIAL_OUT_SHARED_PIN_OE,
    input wire logic SERIAL_IN_SHARED_PIN_IN,
    output logic SERIAL_IN_SHARED_PIN_OUT,
    output logic SERIAL_IN_SHARED_PIN_OE,
    input wire logic SERIAL_CLOCK_SHARED_PIN_IN,
    output logic SERIAL_CLOCK_SHARED_PIN_OUT,
    output logic SERIAL_CLOCK_SHARED_PIN_OE,
    input wire logic [7:0] THIRD_PORT_PINS_IN,
    output logic [7:0] THIRD_PORT_PINS_OUT,
    output logic [7:0] THIRD_PORT_PINS_OE,
    input wire logic FOURTH_PORT_IO_PIN_IN,
    output logic FOURTH_PORT_IO_PIN_OUT,
    output logic FOURTH_PORT_IO_PIN_OE,
    input wire logic CAPTURE_INPUT_PIN_IN,
    input wire logic SERIAL_ENABLE,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_CLOCK_OUT,
    input wire logic SERIAL_CLOCK_OE,
    output logic SERIAL_DATA_IN,
    output logic SERIAL_CLOCK_IN,
    output logic TIMER_CAPTURE_FUNCTION_IN,
    input wire logic EXT_IRQ_N,
    input wire logic IRQ_ACK,
    output logic IRQ_REQ
);

    // Read mux for one port: latch where output, pin level where input
    function automatic logic [7:0] mix_read(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        mix_read = (latch & dir) | (pin & ~dir);
    endfunction

    // Force unimplemented bits to their constant read value
    function automatic logic [7:0] fix_bits(
        input logic [7:0] val,
        input logic [7:0] mask,
        input logic [7:0] fix
    );
        fix_bits = (val & mask) | (fix & ~mask);
    endfunction

    // Data latches and direction registers
    logic [7:0] a_latch;
    logic [7:0] b_latch;
    logic [7:0] c_latch;
    logic [7:0] d_latch;
    logic [7:0] a_dir;
    logic [7:0] b_dir;
    logic [7:0] c_dir;
    logic [7:0] d_dir;

    // Two-stage synchronisers for all pin inputs
    logic [7:0] a_meta;
    logic [7:0] a_sync;
    logic [7:0] c_meta;
    logic [7:0] c_sync;
    logic [2:0] b_meta;
    logic [2:0] b_sync;
    logic [1:0] d_meta;
    logic [1:0] d_sync;
    logic irq_meta;
    logic irq_sync;

    // Interrupt combining
    logic comb_prev;
    logic irq_latch;
    logic comb_n;
    logic [7:0] a_irq_src;

    // Bus decode
    logic wr_en;
    logic rd_en;
    logic [7:0] b_pin;
    logic [7:0] d_pin;
    logic [7:0] next_rdata;

    // Strobe and read/write qualify every access
    assign wr_en = SEL & ~RW;
    assign rd_en = SEL & RW;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            a_meta <= 8'hFF; // Pulled-up idle level: no false fall
            a_sync <= 8'hFF; // after reset on enabled interrupt pins
            c_meta <= 8'h00;
            c_sync <= 8'h00;
            b_meta <= 3'h0;
            b_sync <= 3'h0;
            d_meta <= 2'h0;
            d_sync <= 2'h0;
            irq_meta <= 1'b1;
            irq_sync <= 1'b1;
        end
        else
        begin
            a_meta <= FIRST_PORT_PINS_IN;
            a_sync <= a_meta;
            c_meta <= THIRD_PORT_PINS_IN;
            c_sync <= c_meta;
            b_meta <= {SERIAL_CLOCK_SHARED_PIN_IN, SERIAL_IN_SHARED_PIN_IN,
                       SERIAL_OUT_SHARED_PIN_IN};
            b_sync <= b_meta;
            d_meta <= {CAPTURE_INPUT_PIN_IN, FOURTH_PORT_IO_PIN_IN};
            d_sync <= d_meta;
            irq_meta <= EXT_IRQ_N;
            irq_sync <= irq_meta;
        end
    end

    // Data latches have no reset: contents survive a chip reset
    always_ff @(posedge CLK)
    begin
        if (wr_en)
        begin
            case (ADDR)
                fpp_pkg::OFS_A_DATA: a_latch <= WDATA;
                fpp_pkg::OFS_B_DATA: b_latch <= WDATA & fpp_pkg::B_MASK;
                fpp_pkg::OFS_C_DATA: c_latch <= WDATA;
                fpp_pkg::OFS_D_DATA:
                    d_latch <= WDATA & fpp_pkg::D_DIR_MASK;
                default: ;
            endcase
        end
    end

    // Direction registers cleared at reset so every pin is an input
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            a_dir <= fpp_pkg::DIR_RESET;
            b_dir <= fpp_pkg::DIR_RESET;
            c_dir <= fpp_pkg::DIR_RESET;
            d_dir <= fpp_pkg::DIR_RESET;
        end
        else if (wr_en)
        begin
            case (ADDR)
                fpp_pkg::OFS_A_DIR: a_dir <= WDATA;
                fpp_pkg::OFS_B_DIR: b_dir <= WDATA & fpp_pkg::B_MASK;
                fpp_pkg::OFS_C_DIR: c_dir <= WDATA;
                fpp_pkg::OFS_D_DIR:
                    d_dir <= WDATA & fpp_pkg::D_DIR_MASK;
                default: ;
            endcase
        end
    end

    // Pin levels placed at their bit positions for the read mux
    assign b_pin = {b_sync, 5'h00};
    assign d_pin = {d_sync[1], 1'b0, d_sync[0], 5'h00};

    // Read data, one cycle after the strobe
    always_comb
    begin
        case (ADDR)
            fpp_pkg::OFS_A_DATA: next_rdata = mix_read(a_latch, a_dir, a_sync);
            fpp_pkg::OFS_B_DATA:
                next_rdata = fix_bits(mix_read(b_latch, b_dir, b_pin),
                                      fpp_pkg::B_MASK, fpp_pkg::B_DATA_FIX);
            fpp_pkg::OFS_C_DATA: next_rdata = mix_read(c_latch, c_dir, c_sync);
            // Capture bit has no direction, so always reads the pin
            fpp_pkg::OFS_D_DATA:
                next_rdata = fix_bits(mix_read(d_latch, d_dir, d_pin),
                                      fpp_pkg::D_DATA_MASK,
                                      fpp_pkg::D_DATA_FIX);
            fpp_pkg::OFS_A_DIR: next_rdata = a_dir;
            fpp_pkg::OFS_B_DIR:
                next_rdata = fix_bits(b_dir, fpp_pkg::B_MASK,
                                      fpp_pkg::B_DIR_FIX);
            fpp_pkg::OFS_C_DIR: next_rdata = c_dir;
            fpp_pkg::OFS_D_DIR:
                next_rdata = fix_bits(d_dir, fpp_pkg::D_DIR_MASK,
                                      fpp_pkg::D_DIR_FIX);
            default: next_rdata = fpp_pkg::RDATA_RESET;
        endcase
    end

    // Read register holds its last value between reads
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            RDATA <= fpp_pkg::RDATA_RESET;
        else if (rd_en)
            RDATA <= next_rdata;
    end

    // Pins A, C and D5; latch drives only where direction is one.
    // Gating out by direction keeps an unwritten latch off the pin.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            FIRST_PORT_PINS_OUT <= 8'h00;
            FIRST_PORT_PINS_OE <= 8'h00;
            THIRD_PORT_PINS_OUT <= 8'h00;
            THIRD_PORT_PINS_OE <= 8'h00;
            FOURTH_PORT_IO_PIN_OUT <= 1'b0;
            FOURTH_PORT_IO_PIN_OE <= 1'b0;
        end
        else
        begin
            FIRST_PORT_PINS_OUT <= a_latch & a_dir;
            FIRST_PORT_PINS_OE <= a_dir;
            THIRD_PORT_PINS_OUT <= c_latch & c_dir;
            THIRD_PORT_PINS_OE <= c_dir;
            FOURTH_PORT_IO_PIN_OUT <= d_latch[fpp_pkg::D_IO_BIT]
                                      & d_dir[fpp_pkg::D_IO_BIT];
            FOURTH_PORT_IO_PIN_OE <= d_dir[fpp_pkg::D_IO_BIT];
        end
    end

    // Port B pins; serial peripheral takes them over while enabled
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            SERIAL_OUT_SHARED_PIN_OUT <= 1'b0;
            SERIAL_OUT_SHARED_PIN_OE <= 1'b0;
            SERIAL_IN_SHARED_PIN_OUT <= 1'b0;
            SERIAL_IN_SHARED_PIN_OE <= 1'b0;
            SERIAL_CLOCK_SHARED_PIN_OUT <= 1'b0;
            SERIAL_CLOCK_SHARED_PIN_OE <= 1'b0;
        end
        else if (SERIAL_ENABLE)
        begin
            SERIAL_OUT_SHARED_PIN_OUT <= SERIAL_DATA_OUT;
            SERIAL_OUT_SHARED_PIN_OE <= 1'b1;
            SERIAL_IN_SHARED_PIN_OUT <= 1'b0;
            SERIAL_IN_SHARED_PIN_OE <= 1'b0;
            SERIAL_CLOCK_SHARED_PIN_OUT <= SERIAL_CLOCK_OUT;
            SERIAL_CLOCK_SHARED_PIN_OE <= SERIAL_CLOCK_OE;
        end
        else
        begin
            SERIAL_OUT_SHARED_PIN_OUT <= b_latch[fpp_pkg::B_SDO_BIT]
                                         & b_dir[fpp_pkg::B_SDO_BIT];
            SERIAL_OUT_SHARED_PIN_OE <= b_dir[fpp_pkg::B_SDO_BIT];
            SERIAL_IN_SHARED_PIN_OUT <= b_latch[fpp_pkg::B_SDI_BIT]
                                        & b_dir[fpp_pkg::B_SDI_BIT];
            SERIAL_IN_SHARED_PIN_OE <= b_dir[fpp_pkg::B_SDI_BIT];
            SERIAL_CLOCK_SHARED_PIN_OUT <= b_latch[fpp_pkg::B_SCK_BIT]
                                           & b_dir[fpp_pkg::B_SCK_BIT];
            SERIAL_CLOCK_SHARED_PIN_OE <= b_dir[fpp_pkg::B_SCK_BIT];
        end
    end

    // Synchronised pin levels handed to serial and timer logic
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            SERIAL_DATA_IN <= 1'b0;
            SERIAL_CLOCK_IN <= 1'b0;
            TIMER_CAPTURE_FUNCTION_IN <= 1'b0;
            FIRST_PORT_PULLUP <= 8'h00;
        end
        else
        begin
            SERIAL_DATA_IN <= b_sync[1];
            SERIAL_CLOCK_IN <= b_sync[2];
            TIMER_CAPTURE_FUNCTION_IN <= d_sync[1];
            FIRST_PORT_PULLUP <= PULLUP_MASK;
        end
    end

    // Active-low sources: enabled A pins that are inputs, plus the pin
    assign a_irq_src = IRQ_MASK & ~a_dir;
    assign comb_n = irq_sync & (&(a_sync | ~a_irq_src));

    // Falling edge sets the latch; a new edge beats the acknowledge
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            comb_prev <= 1'b1;
            irq_latch <= 1'b0;
        end
        else
        begin
            comb_prev <= comb_n;
            if (comb_prev & ~comb_n)
                irq_latch <= 1'b1;
            else if (IRQ_ACK)
                irq_latch <= 1'b0;
        end
    end

    // Request: latch, or low level too when level sense is built in
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            IRQ_REQ <= 1'b0;
        else
            IRQ_REQ <= irq_latch | (LEVEL_SENSE & ~comb_n);
    end

endmodule

// file: bench/fpp_cpu_model.sv
// CPU core bus master model for the port registers
`timescale 1ns/1ps
module fpp_cpu_model (
    input wire logic clk,
    output logic sel = 1'b0,
    output logic rw = 1'b1,
    output logic [2:0] addr = 3'h0,
    output logic [7:0] wd = 8'h00
);
    // One byte per strobe, held up to the taking edge
    task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        sel <= 1'b1;
        rw <= r;
        addr <= a;
        wd <= d;
        @(posedge clk);
        // Qualifiers scrambled so a late sample cannot pass
        sel <= 1'b0;
        rw <= ~r;
        addr <= ~a;
        wd <= ~d;
    endtask
endmodule

// file: bench/fpp_ports_properties.sv
// Concurrent checks on port pins and register reads
`timescale 1ns/1ps
module fpp_ports_properties #(
    parameter logic [7:0] PULLUP_MASK = 8'h00,
    parameter logic [7:0] IRQ_MASK = 8'h00
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SEL,
    input wire logic RW,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] FIRST_PORT_PINS_IN,
    input wire logic [7:0] FIRST_PORT_PINS_OUT,
    input wire logic [7:0] FIRST_PORT_PINS_OE,
    input wire logic [7:0] FIRST_PORT_PULLUP,
    input wire logic CAPTURE_INPUT_PIN_IN,
    input wire logic EXT_IRQ_N,
    input wire logic IRQ_REQ
);
    logic wr;
    logic rd;
    // Decoded strobes
    assign wr = SEL && !RW;
    assign rd = SEL && RW;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Direction write shows on the enables two edges later
    property p_dir_oe;
        wr && ADDR == 3'h4 ##1 !(wr && ADDR == 3'h4)
            |=> FIRST_PORT_PINS_OE == $past(WDATA, 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("enable wrong");
    property p_gate;
        (FIRST_PORT_PINS_OUT & ~FIRST_PORT_PINS_OE) == 8'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("drive on input");
    // Fixed bits of the narrow ports
    property p_b_fix;
        rd && ADDR == 3'h1 |=> RDATA[4:0] == 5'h00;
    endproperty
    a_b_fix: assert property (p_b_fix) else $error("b data fixed");
    property p_b_dir;
        rd && ADDR == 3'h5 |=> RDATA[4:0] == 5'h1F;
    endproperty
    a_b_dir: assert property (p_b_dir) else $error("b dir fixed");
    property p_d_fix;
        rd && ADDR == 3'h3 |=> RDATA[6] == 1'b0 && RDATA[4:0] == 5'h10;
    endproperty
    a_d_fix: assert property (p_d_fix) else $error("d data fixed");
    // Sync lag covered by a steady pin
    property p_cap;
        $stable(CAPTURE_INPUT_PIN_IN) [*3] ##0 rd && ADDR == 3'h3
            |=> RDATA[7] == $past(CAPTURE_INPUT_PIN_IN);
    endproperty
    a_cap: assert property (p_cap) else $error("capture read");
    property p_pull;
        $past(NRST) |-> FIRST_PORT_PULLUP == PULLUP_MASK;
    endproperty
    a_pull: assert property (p_pull) else $error("pullup wrong");
    property p_irq;
        $fell(EXT_IRQ_N) && &(FIRST_PORT_PINS_IN | FIRST_PORT_PINS_OE
            | ~IRQ_MASK) |-> ##[1:5] IRQ_REQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    // Main scenarios reached
    c_dir: cover property (wr && ADDR == 3'h4);
    c_irq: cover property ($rose(IRQ_REQ));
    c_cap: cover property (rd && ADDR == 3'h3);
endmodule
bind fpp_ports fpp_ports_properties #(
    .PULLUP_MASK(PULLUP_MASK), .IRQ_MASK(IRQ_MASK)
) u_props (
    .CLK(CLK), .NRST(NRST), .SEL(SEL), .RW(RW), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .FIRST_PORT_PINS_IN(FIRST_PORT_PINS_IN),
    .FIRST_PORT_PINS_OUT(FIRST_PORT_PINS_OUT),
    .FIRST_PORT_PINS_OE(FIRST_PORT_PINS_OE),
    .FIRST_PORT_PULLUP(FIRST_PORT_PULLUP),
    .CAPTURE_INPUT_PIN_IN(CAPTURE_INPUT_PIN_IN),
    .EXT_IRQ_N(EXT_IRQ_N), .IRQ_REQ(IRQ_REQ)
);

// file: bench/test_four_port_parallel_io.sv
// Self-checking bench for the four parallel ports
`timescale 1ns/1ps
module test_four_port_parallel_io;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel, rw, pend = 1'b0, cap = 1'b0, sen = 1'b0, sdo = 1'b0;
    logic ext_n = 1'b1, ack = 1'b0, dout, doe, sdi, sci, tci, irq;
    logic pd = 1'b0, sco = 1'b0, scoe = 1'b0;
    logic [2:0] addr, pb = 3'h0;
    wire [2:0] bo, be;
    logic [7:0] wd, rdata, pa = 8'hFF, pc = 8'h00, ao, ae, pu, co, ce, d, r;
    logic [7:0] eq[$], mq[$];
    int err_count = 0, compares = 0, cyc = 0, i;
    always #2.5 clk = ~clk;
    fpp_ports #(.PULLUP_MASK(8'h0F), .IRQ_MASK(8'h0F), .LEVEL_SENSE(1'b0))
    u_dut (
        .CLK(clk), .NRST(nrst), .SEL(sel), .RW(rw), .ADDR(addr),
        .WDATA(wd), .RDATA(rdata), .FIRST_PORT_PINS_IN(pa),
        .FIRST_PORT_PINS_OUT(ao), .FIRST_PORT_PINS_OE(ae),
        .FIRST_PORT_PULLUP(pu), .SERIAL_OUT_SHARED_PIN_IN(pb[0]),
        .SERIAL_OUT_SHARED_PIN_OUT(bo[0]), .SERIAL_OUT_SHARED_PIN_OE(be[0]),
        .SERIAL_IN_SHARED_PIN_IN(pb[1]), .SERIAL_IN_SHARED_PIN_OUT(bo[1]),
        .SERIAL_IN_SHARED_PIN_OE(be[1]), .SERIAL_CLOCK_SHARED_PIN_IN(pb[2]),
        .SERIAL_CLOCK_SHARED_PIN_OUT(bo[2]),
        .SERIAL_CLOCK_SHARED_PIN_OE(be[2]), .THIRD_PORT_PINS_IN(pc),
        .THIRD_PORT_PINS_OUT(co), .THIRD_PORT_PINS_OE(ce),
        .FOURTH_PORT_IO_PIN_IN(pd), .FOURTH_PORT_IO_PIN_OUT(dout),
        .FOURTH_PORT_IO_PIN_OE(doe), .CAPTURE_INPUT_PIN_IN(cap),
        .SERIAL_ENABLE(sen), .SERIAL_DATA_OUT(sdo), .SERIAL_CLOCK_OUT(sco),
        .SERIAL_CLOCK_OE(scoe), .SERIAL_DATA_IN(sdi), .SERIAL_CLOCK_IN(sci),
        .TIMER_CAPTURE_FUNCTION_IN(tci), .EXT_IRQ_N(ext_n), .IRQ_ACK(ack),
        .IRQ_REQ(irq)
    );
    fpp_cpu_model u_cpu (.clk(clk), .sel(sel), .rw(rw), .addr(addr), .wd(wd));
    task automatic check(string n, logic [7:0] s, logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Expected read noted before the access goes out
    task automatic rd(logic [2:0] a, logic [7:0] e, logic [7:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        u_cpu.acc(1'b1, a, 8'h00);
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] v);
        u_cpu.acc(1'b0, a, v);
    endtask
    // Three edges cover the two-flop pin sync
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic done(string s);
        $display("test %s done", s);
    endtask
    // Interrupt stays latched until acknowledged
    task automatic irq_chk(logic e);
        repeat (8) @(posedge clk);
        #1;
        check("irq", irq, e);
        @(posedge clk);
        ext_n <= 1'b1;
        pa[0] <= 1'b1;
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        settle;
        check("irq_clear", irq, 1'b0);
    endtask
    task automatic finish_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Read data lands one edge after the strobe
    always @(posedge clk) pend <= sel && rw && nrst;
    always @(negedge clk)
        if (pend)
            check("rdata", rdata & mq.pop_front(), eq.pop_front());
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test;
        end
    end
    initial
    begin
        void'($urandom(32'hb5ac));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        settle;
        check("pullup", pu, 8'h0F);
        check("a_oe", ae, 8'h00);
        check("irq_rst", irq, 1'b0);
        rd(3'h4, 8'h00, 8'hFF);
        rd(3'h7, 8'h00, 8'hFF);
        done("reset");
        @(posedge clk);
        pa <= 8'($urandom) | 8'h0F;
        pc <= 8'($urandom);
        for (i = 0; i < 2; i++)
        begin
            d = 8'($urandom);
            r = 8'($urandom);
            wr(3'(i * 2), d);
            settle;
            check("oe", i ? ce : ae, 8'h00);
            check("out", i ? co : ao, 8'h00);
            rd(3'(i * 2), i ? pc : pa, 8'hFF);
            wr(3'(i * 2 + 4), r);
            settle;
            check("oe", i ? ce : ae, r);
            check("out", i ? co : ao, d & r);
            rd(3'(i * 2), (d & r) | ((i ? pc : pa) & ~r), 8'hFF);
            wr(3'(i * 2 + 4), 8'h00);
        end
        done("ports_a_c");
        wr(3'h1, 8'hFF);
        wr(3'h5, 8'hFF);
        settle;
        check("b_oe", {5'h00, be}, 8'h07);
        check("b_out", {5'h00, bo}, 8'h07);
        rd(3'h5, 8'hFF, 8'hFF);
        rd(3'h1, 8'hE0, 8'hFF);
        wr(3'h5, 8'h00);
        pb <= 3'b110;
        sen <= 1'b1;
        sdo <= 1'b1;
        sco <= 1'b1;
        scoe <= 1'b1;
        settle;
        check("sen_oe", {5'h00, be}, 8'h05);
        check("sen_out", {5'h00, bo}, 8'h05);
        check("sdo", bo[0], 1'b1);
        check("sdi", sdi, 1'b1);
        check("sck", sci, 1'b1);
        rd(3'h1, 8'hC0, 8'hFF);
        done("port_b");
        wr(3'h7, 8'hFF);
        wr(3'h3, 8'hFF);
        settle;
        check("d_oe", doe, 1'b1);
        check("d_out", dout, 1'b1);
        rd(3'h7, 8'h20, 8'hFF);
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk);
            cap <= i[0];
            settle;
            check("timer_capture_function", tci, i[0]);
            rd(3'h3, {i[0], 7'h30}, 8'hFF);
        end
        // Bit 5 back to input: pin level replaces the latch
        wr(3'h7, 8'h00);
        pd <= 1'b1;
        settle;
        check("d_in_oe", doe, 1'b0);
        rd(3'h3, 8'hB0, 8'hFF);
        done("port_d");
        @(posedge clk);
        ext_n <= 1'b0;
        irq_chk(1'b1);
        for (i = 0; i < 2; i++)
        begin
            wr(3'h4, 8'(i));
            pa[0] <= 1'b0;
            irq_chk(!i[0]);
        end
        wr(3'h4, 8'h00);
        done("irq");
        wr(3'h4, 8'hFF);
        wr(3'h0, 8'h5A);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        settle;
        check("a_oe", ae, 8'h00);
        check("irq_mid", irq, 1'b0);
        wr(3'h4, 8'hFF);
        rd(3'h0, 8'h5A, 8'hFF);
        settle;
        done("mid_reset");
        finish_test;
    end
endmodule
